/* src/dfh_map.vh */
// register map, field positions and timing constants of the display timing block
`ifndef DFH_MAP_VH
`define DFH_MAP_VH
`define DFH_FRMSZ_OFF 12'h000
`define DFH_HORIZONTAL_BLANK_OUT_OFF 12'h004
`define DFH_MODE_OFF 12'h008
`define DFH_STAT_OFF 12'h00c
`define DFH_HI_LSB 16
`define DFH_HI_MSB 27
`define DFH_LO_LSB 0
`define DFH_LO_MSB 11
`define DFH_DLY_BIT 15
`define DFH_FRMSZ_MASK 32'h0fff0fff
`define DFH_HORIZONTAL_BLANK_OUT_MASK 32'h0fff8fff
`define DFH_MODE_MASK 32'h00000007
`define DFH_REG_RST 32'h00000000
`define DFH_MODE_RST 3'h0
`define DFH_MODE_BT656 3'h0
`define DFH_MODE_RAW8 3'h2
`define DFH_MODE_YC8 3'h4
`define DFH_MODE_RAW16 3'h6
`define DFH_RELEASE_DELAY 3'h4
`define DFH_RESP_OKAY 2'h0
`define DFH_RESP_SLVERR 2'h2
`endif

/* src/dfh_release_delay.v */
// shift line that delays the blanking release by a fixed number of clocks
`timescale 1ns/1ps
module dfh_release_delay #(
  parameter DEPTH = 4
) (
  input wire mclk,
  input wire arst_n,
  input wire stopIn,
  output wire stopDelayed
);
  reg [DEPTH-1:0] pipe_r;
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : stage
      always @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
          pipe_r[i] <= 1'b0;
        else if (i == 0)
          pipe_r[i] <= stopIn;
        else
          pipe_r[i] <= pipe_r[(i == 0) ? 0 : i - 1];
      end
    end
  endgenerate
  assign stopDelayed = pipe_r[DEPTH-1];
endmodule

/* src/dfh_timing.v */
// display frame counters, horizontal blanking and EAV/SAV code placement
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "dfh_map.vh"
module dfh_timing #(
  parameter CW = 12
) (
  input wire mclk,
  input wire arst_n,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg horizontalBlankOut,
  output reg eavStrobe,
  output reg savStrobe,
  output reg [CW-1:0] framePixelCounter,
  output reg [CW-1:0] frameLineCounter
);
  reg [31:0] frameSize_r;
  reg [31:0] hblank_r;
  reg [2:0] mode_r;
  reg [11:0] awAddr_r;
  reg awHeld_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;
  reg wHeld_r;
  reg [CW-1:0] pixel_nxt;
  reg [CW-1:0] line_nxt;
  reg [31:0] rdata_nxt;
  reg rdOk_nxt;
  reg [31:0] merged;
  wire doWrite;
  wire [CW-1:0] lineWidth;
  wire [CW-1:0] frameHeight;
  wire [CW-1:0] hblankStartPos;
  wire [CW-1:0] hblankStopPos;
  wire hblankDelayEnable;
  wire codedMode;
  wire atStart;
  wire atStop;
  wire stopDelayed;
  wire releaseNow;

  // write channel: address and data taken independently, held until used
  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      awAddr_r <= 12'h000;
      awHeld_r <= 1'b0;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      wHeld_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_r <= s_axi_awaddr;
        awHeld_r <= 1'b1;
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        wHeld_r <= 1'b1;
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  // byte-lane merge of write data over the current register word
  always @* begin
    case (awAddr_r[11:2])
      `DFH_FRMSZ_OFF >> 2: merged = frameSize_r;
      `DFH_HORIZONTAL_BLANK_OUT_OFF >> 2: merged = hblank_r;
      `DFH_MODE_OFF >> 2: merged = {29'h0, mode_r};
      default: merged = 32'h00000000;
    endcase
    if (wStrb_r[0])
      merged[7:0] = wData_r[7:0];
    if (wStrb_r[1])
      merged[15:8] = wData_r[15:8];
    if (wStrb_r[2])
      merged[23:16] = wData_r[23:16];
    if (wStrb_r[3])
      merged[31:24] = wData_r[31:24];
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      frameSize_r <= `DFH_REG_RST;
      hblank_r <= `DFH_REG_RST;
      mode_r <= `DFH_MODE_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DFH_RESP_OKAY;
    end else begin
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `DFH_RESP_OKAY;
        case (awAddr_r[11:2])
          `DFH_FRMSZ_OFF >> 2:
            frameSize_r <= merged & `DFH_FRMSZ_MASK;
          `DFH_HORIZONTAL_BLANK_OUT_OFF >> 2:
            hblank_r <= merged & `DFH_HORIZONTAL_BLANK_OUT_MASK;
          `DFH_MODE_OFF >> 2:
            mode_r <= merged[2:0];
          `DFH_STAT_OFF >> 2: ;
          default:
            s_axi_bresp <= `DFH_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: one read at a time, answer one clock after acceptance
  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    rdata_nxt = 32'h00000000;
    rdOk_nxt = 1'b1;
    case (s_axi_araddr[11:2])
      `DFH_FRMSZ_OFF >> 2: rdata_nxt = frameSize_r;
      `DFH_HORIZONTAL_BLANK_OUT_OFF >> 2: rdata_nxt = hblank_r;
      `DFH_MODE_OFF >> 2: rdata_nxt = {29'h0, mode_r};
      `DFH_STAT_OFF >> 2: begin
        rdata_nxt[27:16] = frameLineCounter;
        rdata_nxt[11:0] = framePixelCounter;
        rdata_nxt[15] = horizontalBlankOut;
      end
      default: rdOk_nxt = 1'b0;
    endcase
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `DFH_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_nxt;
      s_axi_rresp <= rdOk_nxt ? `DFH_RESP_OKAY : `DFH_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // field extraction
  assign frameHeight = frameSize_r[`DFH_HI_MSB:`DFH_HI_LSB];
  assign lineWidth = frameSize_r[`DFH_LO_MSB:`DFH_LO_LSB];
  assign hblankStopPos = hblank_r[`DFH_HI_MSB:`DFH_HI_LSB];
  assign hblankStartPos = hblank_r[`DFH_LO_MSB:`DFH_LO_LSB];
  assign hblankDelayEnable = hblank_r[`DFH_DLY_BIT];
  assign codedMode = (mode_r == `DFH_MODE_BT656) ||
                     (mode_r == `DFH_MODE_YC8);

  // frame counters
  always @* begin
    pixel_nxt = framePixelCounter + 1'b1;
    line_nxt = frameLineCounter;
    if (framePixelCounter >= lineWidth - 1'b1 || lineWidth == 12'h000) begin
      pixel_nxt = {CW{1'b0}};
      line_nxt = frameLineCounter + 1'b1;
      if (frameLineCounter >= frameHeight)
        line_nxt = {{(CW-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      framePixelCounter <= {CW{1'b0}};
      frameLineCounter <= {{(CW-1){1'b0}}, 1'b1};
    end else begin
      framePixelCounter <= pixel_nxt;
      frameLineCounter <= line_nxt;
    end
  end

  assign atStart = (framePixelCounter == hblankStartPos);
  assign atStop = (framePixelCounter == hblankStopPos);

  dfh_release_delay #(
    .DEPTH(`DFH_RELEASE_DELAY)
  ) u_delay (
    .mclk(mclk),
    .arst_n(arst_n),
    .stopIn(atStop),
    .stopDelayed(stopDelayed)
  );

  // delayed release only in coded modes; raw mode ignores the bit
  assign releaseNow = (codedMode && hblankDelayEnable) ?
                      stopDelayed : atStop;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      horizontalBlankOut <= 1'b0;
      eavStrobe <= 1'b0;
      savStrobe <= 1'b0;
    end else begin
      if (atStart)
        horizontalBlankOut <= 1'b1;
      else if (releaseNow)
        horizontalBlankOut <= 1'b0;
      eavStrobe <= codedMode && atStart;
      savStrobe <= codedMode && atStop;
    end
  end
endmodule

/* tb/dfh_timing_monitor.sv */
// port assertions for the display timing block
`timescale 1ns/1ps
module dfh_timing_monitor #(
  parameter CW = 12
) (
  input wire mclk,
  input wire arst_n,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire horizontalBlankOut,
  input wire eavStrobe,
  input wire savStrobe,
  input wire [CW-1:0] framePixelCounter,
  input wire [CW-1:0] frameLineCounter
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence released;
    ##[0:4] !horizontalBlankOut;
  endsequence
  chk_pixel_step: assert property (
    1 |=> framePixelCounter == 0 ||
    framePixelCounter == $past(framePixelCounter) + 1)
    else $error("pixel counter skipped");
  chk_line_hold: assert property (
    framePixelCounter != 0 |-> $stable(frameLineCounter))
    else $error("line moved mid line");
  chk_line_nonzero: assert property (
    frameLineCounter != 0) else $error("line counter at zero");
  // a zero line width parks the counter on the start pixel
  chk_eav_pulse: assert property (
    eavStrobe && framePixelCounter != 0 |=> !eavStrobe)
    else $error("eav strobe too long");
  chk_eav_blank: assert property (
    eavStrobe |-> horizontalBlankOut) else $error("eav outside blank");
  // start wins when start and stop share a pixel
  chk_sav_release: assert property (
    savStrobe && !eavStrobe |-> released)
    else $error("blank not released");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped");
  chk_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
endmodule

bind dfh_timing dfh_timing_monitor #(.CW(CW)) mon_u (.mclk(mclk),
  .arst_n(arst_n), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .horizontalBlankOut(horizontalBlankOut),
  .eavStrobe(eavStrobe), .savStrobe(savStrobe),
  .framePixelCounter(framePixelCounter),
  .frameLineCounter(frameLineCounter));

/* tb/dfh_display_sink.sv */
// display model counting the timing codes it receives
`timescale 1ns/1ps
module dfh_display_sink (
  input wire mclk,
  input wire arst_n,
  input wire eavStrobe,
  input wire savStrobe,
  output integer eavCount,
  output integer savCount
);
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      eavCount <= 0;
      savCount <= 0;
    end else begin
      eavCount <= eavCount + eavStrobe;
      savCount <= savCount + savStrobe;
    end
  end
endmodule

/* tb/tb_top.sv */
// self-checking bench for the display timing block
`timescale 1ns/1ps
`include "dfh_map.vh"
module tb_top;
  logic mclk = 0, arst_n = 0, awValid = 0, wValid = 0, bReady = 0;
  logic arValid = 0, rReady = 0;
  logic [11:0] awAddr = 0, arAddr = 0;
  logic [31:0] wData = 0, rdWord;
  logic [1:0] rdResp;
  wire awReady, wReady, bValid, arReady, rValid, hblank, eav, sav;
  wire [1:0] bResp, rResp;
  wire [31:0] rData;
  wire [11:0] pix, line;
  integer eavCnt, savCnt, bad_count = 0, total_checks = 0;
  always #4 mclk = ~mclk;
  dfh_timing dut_u (.mclk(mclk), .arst_n(arst_n), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .horizontalBlankOut(hblank), .eavStrobe(eav), .savStrobe(sav),
    .framePixelCounter(pix), .frameLineCounter(line));
  dfh_display_sink sink_u (.mclk(mclk), .arst_n(arst_n), .eavStrobe(eav),
    .savStrobe(sav), .eavCount(eavCnt), .savCount(savCnt));
  task complete_run;
    if (bad_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task check(input string what, input [31:0] exp, input [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    logic aT, dT;
    @(posedge mclk);
    awAddr <= a;
    wData <= d;
    awValid <= 1;
    wValid <= 1;
    bReady <= 1;
    while (awValid || wValid) begin
      @(negedge mclk);
      aT = awReady;
      dT = wReady;
      @(posedge mclk);
      if (aT) awValid <= 0;
      if (dT) wValid <= 0;
    end
    do @(negedge mclk); while (!bValid);
    @(posedge mclk);
    bReady <= 0;
  endtask
  task rd(input [11:0] a);
    @(posedge mclk);
    arAddr <= a;
    arValid <= 1;
    rReady <= 1;
    do @(negedge mclk); while (!arReady);
    @(posedge mclk);
    arValid <= 0;
    do @(negedge mclk); while (!rValid);
    rdWord = rData;
    rdResp = rResp;
    @(posedge mclk);
    rReady <= 0;
  endtask
  task step(input integer n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task wait_pix(input [11:0] p);
    do step(1); while (pix !== p);
  endtask
  task t_regs;
    rd(`DFH_FRMSZ_OFF);
    check("size reset", 0, rdWord);
    rd(`DFH_HORIZONTAL_BLANK_OUT_OFF);
    check("blank reset", 0, rdWord);
    wr(`DFH_FRMSZ_OFF, 32'h020d035a);
    rd(`DFH_FRMSZ_OFF);
    check("coded size", 32'h020d035a, rdWord);
    wr(`DFH_HORIZONTAL_BLANK_OUT_OFF, 32'hffffffff);
    rd(`DFH_HORIZONTAL_BLANK_OUT_OFF);
    check("blank mask", 32'h0fff8fff, rdWord);
    rd(12'h010);
    check("unmapped", `DFH_RESP_SLVERR, rdResp);
  endtask
  task t_count;
    logic [11:0] l;
    wr(`DFH_FRMSZ_OFF, 32'h00030014);
    repeat (4) begin
      wait_pix(19);
      l = line;
      step(1);
      check("pixel wrap", 0, pix);
      check("line", (l >= 3) ? 1 : l + 1, line);
    end
  endtask
  task t_blank(input logic dly);
    wr(`DFH_HORIZONTAL_BLANK_OUT_OFF, 32'h000c0005 | (dly << 15));
    wait_pix(5);
    step(1);
    check("blank rise", 1, hblank);
    check("eav", 1, eav);
    wait_pix(12);
    step(1);
    check("sav", 1, sav);
    check("blank stop", dly, hblank);
    step(3);
    check("blank held", dly, hblank);
    step(1);
    check("blank end", 0, hblank);
  endtask
  task t_raw(input [2:0] m);
    wr(`DFH_MODE_OFF, m);
    wr(`DFH_HORIZONTAL_BLANK_OUT_OFF, 32'h000c8005);
    wait_pix(12);
    step(1);
    check("raw release", 0, hblank);
    check("raw sav", 0, sav);
    step(20);
    check("raw eav", 0, eav);
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    complete_run;
  end
  initial begin
    integer e;
    repeat (12) @(posedge mclk);
    arst_n <= 1;
    t_regs;
    t_count;
    t_blank(0);
    t_blank(1);
    wr(`DFH_MODE_OFF, `DFH_MODE_RAW8);
    e = eavCnt;
    t_raw(`DFH_MODE_RAW8);
    t_raw(`DFH_MODE_RAW16);
    check("sink eav", e, eavCnt);
    wr(`DFH_MODE_OFF, `DFH_MODE_YC8);
    t_blank(1);
    complete_run;
  end
endmodule
